// [hdl/pin_filter.sv]
`timescale 1ns/100ps
module pin_filter #(
  parameter int W = 6
) (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // raw and filtered levels
  input wire logic [W-1:0] raw,
  output logic [W-1:0] level
);
  logic [W-1:0] s1;
  logic [W-1:0] s2;
  logic [W-1:0] s3;
  wire [W-1:0] next_level = (s2 & s3) | (level & (s2 ^ s3));

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s1 <= '0;
      s2 <= '0;
      s3 <= '0;
      level <= '0;
    end else begin
      s1 <= raw;
      s2 <= s1;
      s3 <= s2;
      level <= next_level;
    end
  end
endmodule

// [hdl/sa_capture.sv]
// Summary of operation
// - the bits sampled between start and stop fold into one four-character signature
// - one probe sample per active edge of the measurement clock
// - clock, start and stop edges each selectable rising or falling
// - gate indicator flashes for each completed window, not at gate rate
// - probe activity shown through a fixed-length pulse stretcher
// - probe tip: bright for high, dim for high impedance, dark for low
// - instability set when a signature differs from the one before
// - qualified mode: qualifier level windows which clocked samples enter
// - qualified mode: start and stop both come from the start lead
// - qualifier level selectable high or low, only while qualified mode on
// - indicators behave the same in qualified and normal mode
// - latch off shows every signature, latch on only triggered ones
// - probe switch press stores the measured signature as triggered
// - with instability latching, an unstable signature sets and holds the flag
// - composite of all signatures since clear, with a flag while it is shown
// - after power-up defaults load, the signature memory is cleared, then measuring
// - signature shown on four seven-segment digit positions
// - in qualified mode clock edges count only at the qualifier level
// - edges default to rising and qualification off after power-up
// - a signature is triggered only after a switch press or trigger command
// - clear empties display, composite, memory, instability and aborts the window
`timescale 1ns/100ps
module sa_capture #(
  parameter int unsigned GATE_FLASH = sa_pkg::GATE_FLASH_CYCLES,
  parameter int unsigned PROBE_FLASH = sa_pkg::PROBE_FLASH_CYCLES
) (
  // apb slave
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // timing pod and probe pins
  input wire logic meas_clk,
  input wire logic window_open_lead,
  input wire logic stop_qual_lead,
  input wire logic probe_above_high,
  input wire logic probe_below_low,
  input wire logic probe_switch,
  // indicators
  output logic [27:0] seg_digits,
  output logic gate_activity_indicator,
  output logic probe_activity_indicator,
  output logic probe_tip_led,
  output logic instability_indicator,
  output logic aggregate_value_indicator
);
  import sa_pkg::*;

  gate_state_e state;
  gate_state_e next_state;
  logic [5:0] pin;
  logic [5:0] pin_d;
  logic [7:0] ctrl;
  logic [15:0] lfsr;
  logic [15:0] disp;
  logic [15:0] last_sig;
  logic have_prev;
  logic [15:0] composite;
  logic trig_pend;
  logic [5:0] mem_count;
  logic [4:0] mem_sel;
  logic [4:0] init_idx;
  logic [15:0] mem_rdata;
  logic [19:0] gate_cnt;
  logic [19:0] probe_cnt;
  logic [1:0] dim_cnt;

  pin_filter #(.W(6)) u_filter (
    .pclk(pclk),
    .presetn(presetn),
    .raw({probe_switch, probe_below_low, probe_above_high, stop_qual_lead,
          window_open_lead, meas_clk}),
    .level(pin)
  );

  // apb decode
  wire setup = psel & ~penable;
  wire wr_en = psel & penable & pready & pwrite;
  wire aligned = paddr[1:0] == 2'h0;
  wire mapped = aligned & (paddr <= OFS_MEM_DATA);
  wire wr_ctrl = wr_en & (paddr == OFS_CTRL);
  wire wr_cmd = wr_en & (paddr == OFS_CMD);
  wire wr_sel = wr_en & (paddr == OFS_MEM_SEL);
  wire clear_cmd = wr_cmd & pwdata[CMD_CLEAR];

  // pin edges
  wire clk_lvl = pin[0];
  wire start_lvl = pin[1];
  wire qual_lvl = pin[2];
  wire probe_hi = pin[3];
  wire probe_lo = pin[4];
  wire sw_lvl = pin[5];
  wire clk_rise = clk_lvl & ~pin_d[0];
  wire clk_fall = ~clk_lvl & pin_d[0];
  wire st_rise = start_lvl & ~pin_d[1];
  wire st_fall = ~start_lvl & pin_d[1];
  wire sp_rise = qual_lvl & ~pin_d[2];
  wire sp_fall = ~qual_lvl & pin_d[2];
  wire qual_en = ctrl[CTL_QUAL_EN];
  wire clk_edge = ctrl[CTL_CLK_POL] ? clk_rise : clk_fall;
  wire start_edge = ctrl[CTL_START_POL] ? st_rise : st_fall;
  wire stop_on_start = ctrl[CTL_STOP_POL] ? st_rise : st_fall;
  wire stop_on_stop = ctrl[CTL_STOP_POL] ? sp_rise : sp_fall;
  wire stop_edge = qual_en ? stop_on_start : stop_on_stop;
  wire qual_ok = ~qual_en | (qual_lvl == ctrl[CTL_QUAL_POL]);
  wire clk_acc = (state == S_OPEN) & clk_edge & qual_ok;
  wire start_acc = (state == S_IDLE) & start_edge;
  wire stop_acc = (state == S_OPEN) & stop_edge;
  wire done = state == S_DONE;
  wire differs = have_prev & (lfsr != last_sig);
  // unlatched flag follows the last compare; latched one drops on clear or latch off
  wire unst_drop = clear_cmd | (done & ~ctrl[CTL_UNST_LATCH]) |
                   (wr_ctrl & ~pwdata[CTL_UNST_LATCH] & ctrl[CTL_UNST_LATCH]);
  wire store = done & trig_pend & (mem_count != MEM_FULL);
  wire trig_ev = (sw_lvl & ~pin_d[5]) | (wr_cmd & pwdata[CMD_TRIGGER]);
  wire probe_chg = (probe_hi ^ pin_d[3]) | (probe_lo ^ pin_d[4]);
  wire probe_z = ~probe_hi & ~probe_lo;
  wire [15:0] shown = ctrl[CTL_SHOW_COMP] ? composite : disp;
  wire [15:0] comp_next = {composite[14:0], composite[15]} ^ lfsr;
  wire mem_we = (state == S_INIT) | store;
  wire [4:0] mem_waddr = (state == S_INIT) ? init_idx : mem_count[4:0];
  wire [15:0] mem_wdata = (state == S_INIT) ? 16'h0000 : lfsr;
  wire [15:0] mem_view = ({1'b0, mem_sel} < mem_count) ? mem_rdata : 16'h0000;
  wire [31:0] status = {18'h0, mem_count, 3'h0, ctrl[CTL_SHOW_COMP], trig_pend,
                        instability_indicator, state == S_OPEN, state != S_INIT};

  logic [31:0] rd_mux;
  always_comb begin
    rd_mux = 32'h0000_0000;
    case (paddr)
      OFS_CTRL: rd_mux = {24'h0, ctrl};
      OFS_STATUS: rd_mux = status;
      OFS_SIG: rd_mux = {16'h0, disp};
      OFS_COMP: rd_mux = {16'h0, composite};
      OFS_MEM_SEL: rd_mux = {27'h0, mem_sel};
      OFS_MEM_DATA: rd_mux = {16'h0, mem_view};
      default: rd_mux = 32'h0000_0000;
    endcase
  end

  // gate state machine
  always_comb begin
    next_state = state;
    case (state)
      S_INIT: if (init_idx == 5'(MEM_DEPTH - 1)) next_state = S_IDLE;
      S_IDLE: if (start_acc) next_state = S_OPEN;
      S_OPEN: if (stop_acc) next_state = S_DONE;
      S_DONE: next_state = S_IDLE;
      default: next_state = S_IDLE;
    endcase
    if (clear_cmd && state != S_INIT) begin
      next_state = S_IDLE;
    end
  end

  sig_store u_store (
    .pclk(pclk),
    .we(mem_we),
    .waddr(mem_waddr),
    .wdata(mem_wdata),
    .raddr(mem_sel),
    .rdata(mem_rdata)
  );

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state <= S_INIT;
      init_idx <= 5'h00;
      pin_d <= 6'h00;
    end else begin
      state <= next_state;
      init_idx <= init_idx + 5'h01;
      pin_d <= pin;
    end
  end

  // apb slave, one wait-free access phase
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0000_0000;
    end else begin
      pready <= setup;
      pslverr <= setup & ~mapped;
      if (setup) begin
        prdata <= mapped ? rd_mux : 32'h0000_0000;
      end
    end
  end

  // settings; qualifier level only changes with qualified mode on
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl <= CTRL_RESET;
      mem_sel <= 5'h00;
    end else begin
      if (wr_ctrl) begin
        ctrl <= {pwdata[7:5], pwdata[3] ? pwdata[4] : ctrl[4], pwdata[3:0]};
      end
      if (wr_sel) begin
        mem_sel <= pwdata[4:0];
      end
    end
  end

  // compression register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      lfsr <= 16'h0000;
    end else if (start_acc) begin
      lfsr <= 16'h0000;
    end else if (clk_acc) begin
      lfsr <= lfsr_step(lfsr, probe_hi);
    end
  end

  // results of a completed window
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      disp <= 16'h0000;
      last_sig <= 16'h0000;
      have_prev <= 1'b0;
      composite <= 16'h0000;
      trig_pend <= 1'b0;
      mem_count <= 6'h00;
      instability_indicator <= 1'b0;
    end else begin
      trig_pend <= (trig_pend & ~done & ~clear_cmd) | trig_ev;
      if (clear_cmd) begin
        disp <= 16'h0000;
        composite <= 16'h0000;
        mem_count <= 6'h00;
        have_prev <= 1'b0;
      end else if (done) begin
        if (!ctrl[CTL_SIG_LATCH] || trig_pend) begin
          disp <= lfsr;
        end
        composite <= comp_next;
        last_sig <= lfsr;
        have_prev <= 1'b1;
        if (store) begin
          mem_count <= mem_count + 6'h01;
        end
      end
      if (done && differs) begin
        instability_indicator <= 1'b1;
      end else if (unst_drop) begin
        instability_indicator <= 1'b0;
      end
    end
  end

  // indicators
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      gate_cnt <= 20'h00000;
      probe_cnt <= 20'h00000;
      dim_cnt <= 2'h0;
      seg_digits <= 28'h0000000;
      gate_activity_indicator <= 1'b0;
      probe_activity_indicator <= 1'b0;
      probe_tip_led <= 1'b0;
      aggregate_value_indicator <= 1'b0;
    end else begin
      gate_cnt <= done ? 20'(GATE_FLASH) : gate_cnt - 20'(gate_cnt != 0);
      probe_cnt <= probe_chg ? 20'(PROBE_FLASH) : probe_cnt - 20'(probe_cnt != 0);
      gate_activity_indicator <= done | (gate_cnt > 20'h00001);
      probe_activity_indicator <= probe_chg | (probe_cnt > 20'h00001);
      dim_cnt <= dim_cnt + 2'h1;
      probe_tip_led <= probe_hi | (probe_z & (dim_cnt == DIM_PHASE_ON));
      seg_digits <= {hex_to_seg(shown[15:12]), hex_to_seg(shown[11:8]),
                     hex_to_seg(shown[7:4]), hex_to_seg(shown[3:0])};
      aggregate_value_indicator <= ctrl[CTL_SHOW_COMP];
    end
  end

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  AST_LFSR_CLEAR: assert property (start_acc |=> lfsr == 16'h0000)
    else $error("signature register not cleared at window start");
  AST_LFSR_STEP: assert property (clk_acc && !start_acc |=>
    lfsr == lfsr_step($past(lfsr), $past(probe_hi)))
    else $error("sample not shifted into signature");
  AST_FREEZE: assert property (state != S_OPEN && !start_acc |=> $stable(lfsr))
    else $error("signature changed outside the window");
  AST_QUAL: assert property (qual_en && qual_lvl != ctrl[CTL_QUAL_POL] |-> !clk_acc)
    else $error("clock accepted outside qualifier level");
  AST_QSTOP: assert property (state == S_OPEN && qual_en && stop_on_start
    && !clear_cmd |=> state == S_DONE)
    else $error("qualified window not closed from start lead");
  AST_UNSTABLE: assert property (done && differs |=> instability_indicator)
    else $error("instability not flagged");
  AST_UNST_FOLLOW: assert property (done && !differs && !ctrl[CTL_UNST_LATCH]
    |=> !instability_indicator)
    else $error("unlatched instability kept after a matching signature");
  AST_HOLD: assert property (ctrl[CTL_UNST_LATCH] && instability_indicator
    && !clear_cmd && !wr_ctrl |=> instability_indicator)
    else $error("latched instability dropped");
  AST_CLEAR: assert property (clear_cmd && state != S_INIT |=>
    state == S_IDLE && composite == 16'h0000 && mem_count == 6'h00)
    else $error("clear did not empty state");
  AST_DISPLAY: assert property (done && !ctrl[CTL_SIG_LATCH] && !clear_cmd
    |=> disp == $past(lfsr))
    else $error("completed signature not displayed");
  AST_STORE: assert property (store && !clear_cmd |=>
    mem_count == $past(mem_count) + 6'h01)
    else $error("triggered signature not stored");
  AST_GATE: assert property (done |=>
    gate_activity_indicator ##1 gate_activity_indicator)
    else $error("gate indicator did not flash");
  AST_SEG: assert property (1'b1 |=>
    seg_digits[27:21] == hex_to_seg($past(shown[15:12])))
    else $error("high digit does not show high nibble");
  AST_TIP: assert property (probe_hi |=> probe_tip_led)
    else $error("tip led dark for logic high");

  COV_DONE: cover property (start_acc ##[1:1000] done);
  COV_STORE: cover property (store);
  COV_UNSTABLE: cover property (done && differs);
  COV_QUAL: cover property (qual_en && clk_acc);
endmodule

// [hdl/sa_pkg.sv]
package sa_pkg;
  // register byte offsets on the apb bus
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_CMD = 8'h04;
  localparam logic [7:0] OFS_STATUS = 8'h08;
  localparam logic [7:0] OFS_SIG = 8'h0c;
  localparam logic [7:0] OFS_COMP = 8'h10;
  localparam logic [7:0] OFS_MEM_SEL = 8'h14;
  localparam logic [7:0] OFS_MEM_DATA = 8'h18;
  // control field positions
  localparam int CTL_CLK_POL = 0;
  localparam int CTL_START_POL = 1;
  localparam int CTL_STOP_POL = 2;
  localparam int CTL_QUAL_EN = 3;
  localparam int CTL_QUAL_POL = 4;
  localparam int CTL_SIG_LATCH = 5;
  localparam int CTL_UNST_LATCH = 6;
  localparam int CTL_SHOW_COMP = 7;
  localparam logic [7:0] CTRL_RESET = 8'h17;
  // command field positions
  localparam int CMD_CLEAR = 0;
  localparam int CMD_TRIGGER = 1;
  // signature store
  localparam int MEM_DEPTH = 32;
  localparam int MEM_AW = 5;
  localparam logic [5:0] MEM_FULL = 6'h20;
  localparam int SIG_W = 16;
  // timing
  localparam int CLK_PERIOD_NS = 50;
  localparam int GATE_FLASH_NS = 50000000;
  localparam int PROBE_FLASH_NS = 20000000;
  localparam int GATE_FLASH_CYCLES = GATE_FLASH_NS / CLK_PERIOD_NS;
  localparam int PROBE_FLASH_CYCLES = PROBE_FLASH_NS / CLK_PERIOD_NS;
  localparam logic [1:0] DIM_PHASE_ON = 2'h0;

  typedef enum logic [1:0] {S_INIT, S_IDLE, S_OPEN, S_DONE} gate_state_e;

  // one shift of the compression register, taps 7 9 12 16
  function automatic logic [15:0] lfsr_step(input logic [15:0] r, input logic d);
    logic fb;
    fb = d ^ r[6] ^ r[8] ^ r[11] ^ r[15];
    return {r[14:0], fb};
  endfunction

  // hex nibble to segments gfedcba, active high
  function automatic logic [6:0] hex_to_seg(input logic [3:0] n);
    logic [6:0] s;
    s = 7'h00;
    case (n)
      4'h0: s = 7'h3f;
      4'h1: s = 7'h06;
      4'h2: s = 7'h5b;
      4'h3: s = 7'h4f;
      4'h4: s = 7'h66;
      4'h5: s = 7'h6d;
      4'h6: s = 7'h7d;
      4'h7: s = 7'h07;
      4'h8: s = 7'h7f;
      4'h9: s = 7'h6f;
      4'ha: s = 7'h77;
      4'hb: s = 7'h7c;
      4'hc: s = 7'h39;
      4'hd: s = 7'h5e;
      4'he: s = 7'h79;
      default: s = 7'h71;
    endcase
    return s;
  endfunction
endpackage

// [hdl/sig_store.sv]
`timescale 1ns/100ps
module sig_store (
  // clock
  input wire logic pclk,
  // write port
  input wire logic we,
  input wire logic [sa_pkg::MEM_AW-1:0] waddr,
  input wire logic [sa_pkg::SIG_W-1:0] wdata,
  // registered read port
  input wire logic [sa_pkg::MEM_AW-1:0] raddr,
  output logic [sa_pkg::SIG_W-1:0] rdata
);
  import sa_pkg::*;
  logic [SIG_W-1:0] mem [MEM_DEPTH];

  always_ff @(posedge pclk) begin
    if (we) begin
      mem[waddr] <= wdata;
    end
    rdata <= mem[raddr];
  end
endmodule

// [tb/cut_model.sv]
`timescale 1ns/100ps
module cut_model (
  // timing pod leads
  output logic meas_clk,
  output logic window_open_lead,
  output logic stop_qual_lead,
  // probe comparators
  output logic probe_above_high,
  output logic probe_below_low
);
  // active levels of clock, start and stop edges
  logic cp = 1'b1;
  logic sp = 1'b1;
  logic tp = 1'b1;
  initial begin
    meas_clk = 1'b0;
    window_open_lead = 1'b0;
    stop_qual_lead = 1'b0;
    probe_above_high = 1'b0;
    probe_below_low = 1'b1;
  end
  // {above, below}; both low is high impedance
  task automatic probe(input logic [1:0] s);
    {probe_above_high, probe_below_low} = s;
  endtask
  task automatic idle();
    meas_clk = ~cp;
    window_open_lead = ~sp;
    stop_qual_lead = ~tp;
  endtask
  // one window of n samples; q gives the qualifier level per sample
  task automatic frame(input logic [31:0] d, input int n, input logic qm, input logic [31:0] q);
    #7 window_open_lead = sp;
    #400 window_open_lead = ~sp;
    #400;
    for (int i = 0; i < n; i++) begin
      probe({d[i], ~d[i]});
      stop_qual_lead = qm ? q[i] : ~tp;
      #200 meas_clk = cp;
      #200 meas_clk = ~cp;
    end
    #400;
    if (qm) begin
      stop_qual_lead = ~tp;
      window_open_lead = sp;
      #400 window_open_lead = ~sp;
    end else begin
      stop_qual_lead = tp;
      #400 stop_qual_lead = ~tp;
    end
  endtask
endmodule

// [tb/tb_sa_capture.sv]
`timescale 1ns/100ps
module tb_sa_capture;
  import sa_pkg::*;
  localparam logic [31:0] A = 32'h0012_b4c7;
  localparam logic [31:0] B = 32'h00ed_4b38;
  localparam logic [31:0] Q = 32'h00f0_3c5a;
  localparam logic [31:0] EN = 32'h000f_ffff;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic probe_switch = 1'b0;
  logic [31:0] prdata;
  logic pready, pslverr, meas_clk, window_open_lead, stop_qual_lead;
  logic probe_above_high, probe_below_low, gate_activity_indicator;
  logic probe_activity_indicator, probe_tip_led, instability_indicator;
  logic aggregate_value_indicator;
  logic [27:0] seg_digits;
  int error_cnt = 0;
  int cmp_count = 0;
  int gate_run = 0, gate_len = 0, gate_n = 0, pa_run = 0, pa_len = 0, hz;
  logic [15:0] disp = 16'h0, comp = 16'h0, prev = 16'h0;
  logic have = 1'b0, unst = 1'b0, ulat = 1'b0, slat = 1'b0, trig = 1'b0, erv;
  logic [31:0] rdv;
  logic [6:0] segt [16] = '{7'h3f, 7'h06, 7'h5b, 7'h4f, 7'h66, 7'h6d, 7'h7d, 7'h07,
    7'h7f, 7'h6f, 7'h77, 7'h7c, 7'h39, 7'h5e, 7'h79, 7'h71};

  sa_capture #(.GATE_FLASH(8), .PROBE_FLASH(8)) u_dut (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .meas_clk(meas_clk),
    .window_open_lead(window_open_lead), .stop_qual_lead(stop_qual_lead),
    .probe_above_high(probe_above_high), .probe_below_low(probe_below_low),
    .probe_switch(probe_switch), .seg_digits(seg_digits),
    .gate_activity_indicator(gate_activity_indicator),
    .probe_activity_indicator(probe_activity_indicator), .probe_tip_led(probe_tip_led),
    .instability_indicator(instability_indicator),
    .aggregate_value_indicator(aggregate_value_indicator));
  cut_model u_cut (.meas_clk(meas_clk), .window_open_lead(window_open_lead),
    .stop_qual_lead(stop_qual_lead), .probe_above_high(probe_above_high),
    .probe_below_low(probe_below_low));

  always #25 pclk = ~pclk;
  // length of the last completed pulse of each stretched indicator
  always @(posedge pclk) begin
    gate_run <= gate_activity_indicator === 1'b1 ? gate_run + 1 : 0;
    if (gate_activity_indicator !== 1'b1 && gate_run != 0) gate_len <= gate_run;
    if (gate_activity_indicator !== 1'b1 && gate_run != 0) gate_n <= gate_n + 1;
    pa_run <= probe_activity_indicator === 1'b1 ? pa_run + 1 : 0;
    if (probe_activity_indicator !== 1'b1 && pa_run != 0) pa_len <= pa_run;
  end

  task automatic results();
    if (error_cnt == 0 && cmp_count > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    cmp_count++;
    if (g !== e) begin
      error_cnt++;
      $display("unexpected at %0t: got %h expected %h", $time, g, e);
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] wd,
    output logic [31:0] rd, output logic er);
    int k;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    k = 0;
    do begin
      @(posedge pclk);
      k++;
    end while (pready !== 1'b1 && k < 50);
    if (k >= 50) begin
      error_cnt++;
      $display("unexpected at %0t: no pready", $time);
      results();
    end
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d, rdv, erv);
  endtask
  task automatic rdc(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
    apb(1'b0, a, 32'h0, rdv, erv);
    chk(rdv & m, e);
  endtask
  function automatic logic [15:0] sig_of(input logic [31:0] d, input int n,
    input logic [31:0] en);
    logic [15:0] r;
    r = 16'h0;
    for (int i = 0; i < n; i++) if (en[i]) r = {r[14:0], d[i] ^ r[6] ^ r[8] ^ r[11] ^ r[15]};
    return r;
  endfunction
  task automatic run(input logic [31:0] d, input int n, input logic qm, input logic [31:0] q,
    input logic [31:0] en);
    logic [15:0] s;
    int n0;
    s = sig_of(d, n, en);
    n0 = gate_n;
    u_cut.frame(d, n, qm, q);
    repeat (16) @(posedge pclk);
    comp = {comp[14:0], comp[15]} ^ s;
    unst = (ulat & unst) | (have & (s != prev));
    prev = s;
    have = 1'b1;
    if (!slat || trig) disp = s;
    trig = 1'b0;
    rdc(OFS_SIG, 32'hffff, {16'h0, disp});
    rdc(OFS_COMP, 32'hffff, {16'h0, comp});
    chk({31'h0, instability_indicator}, {31'h0, unst});
    chk({4'h0, seg_digits}, {4'h0, segt[disp[15:12]], segt[disp[11:8]],
      segt[disp[7:4]], segt[disp[3:0]]});
    chk(gate_len, 8);
    chk(gate_n, n0 + 1);
  endtask

  initial begin
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    rdc(OFS_CTRL, 32'hff, 32'h17);
    rdv = 32'h0;
    for (int k = 0; k < 60 && rdv[0] !== 1'b1; k++) apb(1'b0, OFS_STATUS, 32'h0, rdv, erv);
    chk(rdv & 32'h1, 32'h1);
    if (rdv[0] !== 1'b1) results();
    u_cut.probe(2'b10);
    repeat (20) @(posedge pclk);
    chk({31'h0, probe_tip_led}, 32'h1);
    chk(pa_len, 8);
    u_cut.probe(2'b00);
    repeat (20) @(posedge pclk);
    hz = 0;
    repeat (8) begin
      @(posedge pclk);
      hz += (probe_tip_led === 1'b1);
    end
    chk(hz, 2);
    u_cut.probe(2'b01);
    repeat (20) @(posedge pclk);
    chk({31'h0, probe_tip_led}, 32'h0);
    run(A, 20, 1'b0, 32'h0, EN);
    run(A, 20, 1'b0, 32'h0, EN);
    run(B, 20, 1'b0, 32'h0, EN);
    wr(OFS_CTRL, 32'h0);
    {u_cut.cp, u_cut.sp, u_cut.tp} = 3'b000;
    u_cut.idle();
    rdc(OFS_CTRL, 32'hff, 32'h10);
    run(A, 20, 1'b0, 32'h0, EN);
    wr(OFS_CTRL, 32'h17);
    {u_cut.cp, u_cut.sp, u_cut.tp} = 3'b111;
    u_cut.idle();
    wr(OFS_CTRL, 32'h1f);
    run(B, 24, 1'b1, Q, Q & 32'hffffff);
    wr(OFS_CTRL, 32'h0f);
    run(B, 24, 1'b1, Q, ~Q & 32'hffffff);
    apb(1'b0, 8'h1c, 32'h0, rdv, erv);
    chk({31'h0, erv}, 32'h1);
    chk(rdv, 32'h0);
    wr(OFS_CTRL, 32'h27);
    slat = 1'b1;
    run(A, 20, 1'b0, 32'h0, EN);
    probe_switch <= 1'b1;
    repeat (4) @(posedge pclk);
    probe_switch <= 1'b0;
    trig = 1'b1;
    run(B, 20, 1'b0, 32'h0, EN);
    wr(OFS_CMD, 32'h2);
    trig = 1'b1;
    run(A, 20, 1'b0, 32'h0, EN);
    rdc(OFS_STATUS, 32'h3f00, 32'h0200);
    wr(OFS_MEM_SEL, 32'h0);
    repeat (2) @(posedge pclk);
    rdc(OFS_MEM_DATA, 32'hffff, {16'h0, sig_of(B, 20, EN)});
    wr(OFS_CTRL, 32'h47);
    slat = 1'b0;
    ulat = 1'b1;
    run(B, 20, 1'b0, 32'h0, EN);
    run(B, 20, 1'b0, 32'h0, EN);
    wr(OFS_CTRL, 32'h87);
    repeat (3) @(posedge pclk);
    chk({31'h0, aggregate_value_indicator}, 32'h1);
    wr(OFS_CMD, 32'h1);
    repeat (4) @(posedge pclk);
    rdc(OFS_SIG, 32'hffff, 32'h0);
    rdc(OFS_COMP, 32'hffff, 32'h0);
    rdc(OFS_STATUS, 32'h3f04, 32'h0);
    chk({31'h0, instability_indicator}, 32'h0);
    results();
  end
endmodule
